/* File: hw/sp_pkg.sv */
package sp_pkg;
    // ==========================================================
    // register map (byte addresses, one aligned word each)
    // ==========================================================
    localparam logic [7:0] SP_CTRL_OFS   = 8'h00;  // serial_control_reg
    localparam logic [7:0] SP_DATA_OFS   = 8'h04;  // serial_data_buffer
    localparam logic [7:0] SP_STATUS_OFS = 8'h08;  // live activity bits
    localparam logic [7:0] SP_BAUD_OFS   = 8'h0C;  // baud tick reload

    // control field positions
    localparam int SP_RX_DONE_BIT  = 0;
    localparam int SP_TX_DONE_BIT  = 1;
    localparam int SP_NINTH_TX_BIT = 3;
    localparam int SP_NINTH_RX_BIT = 2;
    localparam int SP_REN_BIT      = 4;
    localparam int SP_MPF_BIT      = 5;
    localparam int SP_MODE_LO_BIT  = 6;
    localparam int SP_MODE_HI_BIT  = 7;

    // reset values
    localparam logic [7:0]  SP_CTRL_RST = 8'h00;
    localparam logic [15:0] SP_BAUD_RST = 16'h0000;

    // timing counts
    localparam int SP_MC_CLKS    = 12;  // clocks per machine cycle
    localparam int SP_M0_BITS    = 8;   // data bits per mode 0 transfer
    localparam int SP_DIV16      = 16;  // counter states per bit time
    localparam logic [8:0] SP_RX0_INIT = 9'h0FE;  // 11111110 pattern
    localparam logic [9:0] SP_RX1_INIT = 10'h3FF;

    // operating modes
    typedef enum logic [1:0] {
        SP_MODE_SHIFT = 2'b00,
        SP_MODE_UART8 = 2'b01,
        SP_MODE_UART9 = 2'b10,
        SP_MODE_UART9V = 2'b11
    } sp_mode_t;
endpackage

/* File: hw/sp_serial_port.sv */
// Notes on behaviour
// [RULE_01] receive-done set on completion; software clears
// [RULE_02] two mode bits select one of four
// [RULE_03] data buffer write starts a transmission
// [RULE_04] mode 0 receive needs flag low, enable
// [RULE_05] uart receive starts on start bit if enabled
// [RULE_06] mode 0 data on line0, clock on line1
// [RULE_07] mode 0 write loads marker, send after cycle
// [RULE_08] send routes shift data and clock out
// [RULE_09] mode 0 shift right each active cycle
// [RULE_10] mode 0 final shift, done tenth cycle
// [RULE_11] mode 0 receive loads 11111110 then active
// [RULE_12] mode 0 receive shifts left sampling line0
// [RULE_13] leftmost zero ends receive, loads buffer
// [RULE_14] uart frame: start, eight data, stop
// [RULE_15] receive complete when stop stored
// [RULE_16] uart bit rate from timer overflow
// [RULE_17] uart write loads marker, requests send
// [RULE_18] uart transmit waits for counter rollover
// [RULE_19] start bit, data enable, then shifting
// [RULE_20] uart shift right, final shift on marker
// [RULE_21] transmit-done set after last bit
// [RULE_22] divide-by-16 advances per baud tick
// [RULE_23] idle line high, done flag set
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module sp_serial_port #(
    parameter int MC_CLKS = sp_pkg::SP_MC_CLKS   // system clocks per machine cycle
) (
    input  wire logic        CLK_SYS_I,
    input  wire logic        RESETN_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        TIMER_OVF_I,     // selected timer overflow pulse
    input  wire logic        PORT3_LINE0_I,   // serial data / receive pin
    output logic             PORT3_LINE0_O,
    output logic             PORT3_LINE0_OE_O,
    output logic             PORT3_LINE1_O    // shift clock or uart transmit
);
    import sp_pkg::*;

    // ==========================================================
    // pin synchroniser
    // ==========================================================
    logic rxd_m_q;   // first stage, read only by second
    logic rxd_s_q;   // synchronised receive pin
    logic rxd_p_q;   // previous value, for edge find
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rxd_m_q <= 1'b1;
            rxd_s_q <= 1'b1;
            rxd_p_q <= 1'b1;
        end else begin
            rxd_m_q <= PORT3_LINE0_I;
            rxd_s_q <= rxd_m_q;
            rxd_p_q <= rxd_s_q;
        end
    end

    // ==========================================================
    // machine cycle and baud tick generation
    // ==========================================================
    logic [4:0]  mc_cnt_q;     // position inside machine cycle
    logic [15:0] baud_cnt_q;   // baud tick divider
    logic [15:0] baud_rld_q;   // software divider reload
    logic [3:0]  div16_q;      // divide-by-16 transmit counter
    logic [3:0]  rdiv16_q;     // receive counter, realigned on start
    wire         mc_end   = (mc_cnt_q == 5'(MC_CLKS - 1));
    wire         mc_mid   = (mc_cnt_q == 5'(MC_CLKS / 2 - 1));
    // a tick needs an overflow, so a zero reload gives one tick per overflow
    wire         baud_tick = TIMER_OVF_I && (baud_cnt_q == 16'h0000);
    wire         roll16   = baud_tick && (div16_q == 4'hF);
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            mc_cnt_q   <= 5'h00;
            baud_cnt_q <= 16'h0000;
        end else begin
            mc_cnt_q <= mc_end ? 5'h00 : mc_cnt_q + 5'h01;
            // [RULE_16] timer overflow clocks baud
            if (TIMER_OVF_I)
                baud_cnt_q <= baud_tick ? baud_rld_q : baud_cnt_q - 16'h0001;
        end
    end
    // [RULE_22] advance once per tick
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I)
            div16_q <= 4'h0;
        else if (baud_tick)
            div16_q <= div16_q + 4'h1;
    end

    // ==========================================================
    // control register and mode decode
    // ==========================================================
    logic [7:0] ctrl_q;       // serial_control_reg
    logic [7:0] serial_data_buffer_rx_q;    // received serial_data_buffer
    // [RULE_02] mode from two select bits
    wire sp_mode_t mode = sp_mode_t'({ctrl_q[SP_MODE_HI_BIT], ctrl_q[SP_MODE_LO_BIT]});
    wire m0      = (mode == SP_MODE_SHIFT);
    wire ren     = ctrl_q[SP_REN_BIT];
    wire rx_done_flag = ctrl_q[SP_RX_DONE_BIT];
    // writes land only on the ready edge, once per transfer
    wire apb_wr  = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
    wire wr_ctrl = apb_wr && (PADDR_I == SP_CTRL_OFS);
    // [RULE_03] buffer write starts transmit
    wire wr_data = apb_wr && (PADDR_I == SP_DATA_OFS);
    wire wr_baud = apb_wr && (PADDR_I == SP_BAUD_OFS);
    wire addr_ok = (PADDR_I == SP_CTRL_OFS) || (PADDR_I == SP_DATA_OFS)
                || (PADDR_I == SP_STATUS_OFS) || (PADDR_I == SP_BAUD_OFS);

    // ==========================================================
    // transmitter
    // ==========================================================
    logic [8:0] tsr_q;       // transmit shift register with marker
    logic       tx_req_q;    // write seen, waiting to start
    logic       tx_arm_q;    // mode 0: first machine cycle boundary passed
    logic       send_q;      // transmit-active strobe
    logic       data_en_q;   // uart: shift output enabled
    logic [3:0] tx_bits_q;   // uart bit times since start
    logic       tx_set;      // pulse: set transmit-done
    wire        tsr_last = (tsr_q[8:2] == 7'h00) && tsr_q[1];
    wire        m0_tick  = mc_end;
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            tsr_q     <= 9'h000;
            tx_req_q  <= 1'b0;
            tx_arm_q  <= 1'b0;
            send_q    <= 1'b0;
            data_en_q <= 1'b0;
            tx_bits_q <= 4'h0;
            tx_set    <= 1'b0;
        end else begin
            tx_set <= 1'b0;
            if (wr_data) begin
                // [RULE_07] marker 1 into ninth position
                // [RULE_17] load ninth position and request
                tsr_q     <= {1'b1, PWDATA_I[7:0]};
                tx_req_q  <= 1'b1;
                tx_arm_q  <= 1'b0;
                send_q    <= 1'b0;
                data_en_q <= 1'b0;
            end else if (m0) begin
                // [RULE_07] send one machine cycle after write
                // first boundary arms, second starts: a full cycle always passes
                if (tx_req_q && m0_tick) begin
                    tx_arm_q <= 1'b1;
                    if (tx_arm_q) begin
                        tx_req_q <= 1'b0;
                        tx_arm_q <= 1'b0;
                        send_q   <= 1'b1;
                    end
                end else if (send_q && m0_tick) begin
                    // [RULE_10] final shift and done flag
                    if (tsr_last) begin
                        send_q <= 1'b0;
                        // [RULE_21] done after eighth bit
                        tx_set <= 1'b1;
                    end
                    // [RULE_09] right shift, zero fill
                    tsr_q <= {1'b0, tsr_q[8:1]};
                end
            end else if (roll16) begin
                // [RULE_18] start on counter rollover
                if (tx_req_q) begin
                    tx_req_q  <= 1'b0;
                    send_q    <= 1'b1;
                    tx_bits_q <= 4'h0;
                end else if (send_q) begin
                    tx_bits_q <= tx_bits_q + 4'h1;
                    // [RULE_19] data enable one bit time later
                    data_en_q <= 1'b1;
                    if (data_en_q) begin
                        // [RULE_20] shift right; extra shift on marker
                        tsr_q <= {1'b0, tsr_q[8:1]};
                        if (tsr_q[8:1] == 8'h00) begin
                            // [RULE_23] end frame, idle high
                            send_q    <= 1'b0;
                            data_en_q <= 1'b0;
                            tx_set    <= 1'b1;
                        end
                    end
                end
            end
        end
    end

    // ==========================================================
    // receiver
    // ==========================================================
    logic [9:0] rsr_q;       // receive shift register
    logic       rx_act_q;    // receive-active strobe
    logic       rx_arm_q;    // mode 0: load pending
    logic       rx_busy_q;   // uart: frame in progress
    logic [1:0] vote_q;      // uart majority samples
    logic       rx_set;      // pulse: set receive-done
    logic       rx9_set;     // pulse: store ninth bit
    logic       rx9_val;     // ninth bit value
    wire        fall     = rxd_p_q && !rxd_s_q;
    wire        mid_st   = (rdiv16_q >= 4'h6) && (rdiv16_q <= 4'h8);
    wire        vote     = (vote_q == 2'b11) || (vote_q[0] && rxd_s_q)
                        || (vote_q[1] && rxd_s_q);
    wire        mpf_ok   = !ctrl_q[SP_MPF_BIT] || rsr_q[9];
    // mode 0: first sampled bit ends on the left, so reverse it
    wire [7:0]  rx0_shift = {rsr_q[6:0], rxd_s_q};
    logic [7:0] rx0_byte;    // received byte, lsb first on the wire
    for (genvar gi = 0; gi < 8; gi++) begin : g_rev
        assign rx0_byte[gi] = rx0_shift[7 - gi];
    end
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rsr_q     <= 10'h3FF;
            rx_act_q  <= 1'b0;
            rx_arm_q  <= 1'b0;
            rx_busy_q <= 1'b0;
            rdiv16_q  <= 4'h0;
            vote_q    <= 2'b00;
            serial_data_buffer_rx_q <= 8'h00;
            rx_set    <= 1'b0;
            rx9_set   <= 1'b0;
            rx9_val   <= 1'b0;
        end else begin
            rx_set  <= 1'b0;
            rx9_set <= 1'b0;
            if (m0) begin
                rx_busy_q <= 1'b0;
                // [RULE_04] start only with flag low, enable high
                if (!rx_act_q && !rx_arm_q && !send_q && !tx_req_q
                    && ren && !rx_done_flag && m0_tick) begin
                    rx_arm_q <= 1'b1;
                end else if (rx_arm_q && m0_tick) begin
                    // [RULE_11] load pattern, then receive active
                    rsr_q    <= {1'b1, SP_RX0_INIT};
                    rx_arm_q <= 1'b0;
                    rx_act_q <= 1'b1;
                end else if (rx_act_q && m0_tick) begin
                    // [RULE_12] shift left, sample line0
                    rsr_q <= {rsr_q[8:0], rxd_s_q};
                    // [RULE_13] leftmost zero: final shift, load buffer
                    if (!rsr_q[7]) begin
                        rx_act_q  <= 1'b0;
                        serial_data_buffer_rx_q <= rx0_byte;
                        // [RULE_01] flag after eighth bit
                        rx_set    <= 1'b1;
                    end
                end
            end else begin
                rx_act_q <= 1'b0;
                rx_arm_q <= 1'b0;
                // [RULE_05] start bit begins reception if enabled
                if (!rx_busy_q) begin
                    if (fall && ren) begin
                        rx_busy_q <= 1'b1;
                        rdiv16_q  <= 4'h0;
                        rsr_q     <= SP_RX1_INIT;
                    end
                end else if (baud_tick) begin
                    rdiv16_q <= rdiv16_q + 4'h1;
                    if (mid_st)
                        vote_q <= {vote_q[0], rxd_s_q};
                    if (rdiv16_q == 4'h8) begin
                        // [RULE_14] frame bits, lsb first
                        rsr_q <= {vote, rsr_q[9:1]};
                        if (rsr_q[9:1] == 9'h1FF && vote) begin
                            rx_busy_q <= 1'b0;  // false start
                        end else if (!rsr_q[0]) begin
                            rx_busy_q <= 1'b0;
                            if (!rx_done_flag && mpf_ok) begin
                                serial_data_buffer_rx_q <= rsr_q[8:1];
                                // [RULE_15] stop bit into ninth flag
                                rx9_set <= 1'b1;
                                rx9_val <= rsr_q[9];
                                // [RULE_01] flag after stop, filter permitting
                                rx_set  <= 1'b1;
                            end
                        end
                    end
                end
            end
        end
    end

    // ==========================================================
    // control register: hardware set wins over software clear
    // ==========================================================
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ctrl_q     <= SP_CTRL_RST;
            baud_rld_q <= SP_BAUD_RST;
        end else begin
            if (wr_ctrl)
                ctrl_q <= PWDATA_I[7:0];
            if (rx_set)
                ctrl_q[SP_RX_DONE_BIT] <= 1'b1;
            if (tx_set)
                ctrl_q[SP_TX_DONE_BIT] <= 1'b1;
            if (rx9_set)
                ctrl_q[SP_NINTH_RX_BIT] <= rx9_val;
            if (wr_baud)
                baud_rld_q <= PWDATA_I[15:0];
        end
    end

    // ==========================================================
    // apb read path and pins, all registered
    // ==========================================================
    wire [31:0] rd_mux =
        (PADDR_I == SP_CTRL_OFS)   ? {24'h00_0000, ctrl_q} :
        (PADDR_I == SP_DATA_OFS)   ? {24'h00_0000, serial_data_buffer_rx_q} :
        (PADDR_I == SP_STATUS_OFS) ? {28'h000_0000, rx_busy_q, rx_act_q, tx_req_q, send_q} :
        (PADDR_I == SP_BAUD_OFS)   ? {16'h0000, baud_rld_q} : 32'h0000_0000;
    // [RULE_06] mode 0 clock low in first half of cycle when sending, until mc_mid when receiving
    wire sclk = !(m0 && send_q) || !(mc_cnt_q < 5'(MC_CLKS / 2));
    // [RULE_08] route data and clock while sending
    wire line1_d = m0 ? (sclk && !(rx_act_q && !mc_mid && mc_cnt_q < 5'(MC_CLKS / 2)))
                      : (!send_q || (data_en_q && tsr_q[0]));
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            PRDATA_O         <= 32'h0000_0000;
            PREADY_O         <= 1'b0;
            PSLVERR_O        <= 1'b0;
            PORT3_LINE0_O    <= 1'b1;
            PORT3_LINE0_OE_O <= 1'b0;
            PORT3_LINE1_O    <= 1'b1;
        end else begin
            // one wait state: ready in second access cycle
            PREADY_O         <= PSEL_I && PENABLE_I && !PREADY_O;
            PSLVERR_O        <= PSEL_I && PENABLE_I && !PREADY_O && !addr_ok;
            PRDATA_O         <= rd_mux;
            PORT3_LINE0_O    <= tsr_q[0];
            PORT3_LINE0_OE_O <= m0 && send_q;
            // [RULE_23] uart idle high
            PORT3_LINE1_O    <= line1_d;
        end
    end
endmodule // sp_serial_port
`default_nettype wire

/* File: testbench/sp_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module sp_checker #(
    parameter int MC_CLKS = 12
) (
    input wire logic        CLK_SYS_I,
    input wire logic        RESETN_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [7:0]  PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    input wire logic        PORT3_LINE0_OE_O,
    input wire logic        PORT3_LINE1_O
);
    localparam int D_M0 = 200;  // write to end of a mode 0 send
    localparam int D_U1 = 300;  // write to start bit, one rollover
    // ==========================================
    // helper logic: mode shadow, send length
    logic [1:0]      mode_q;
    logic [9:0]      oe_cnt_q;
    wire logic acc = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
    wire logic wr_data = acc && (PADDR_I == 8'h04);
    // mode follows the control writes that the slave accepts
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            mode_q <= 2'b00;
            oe_cnt_q <= '0;
        end else begin
            if (acc && PADDR_I == 8'h00) mode_q <= PWDATA_I[7:6];
            oe_cnt_q <= PORT3_LINE0_OE_O ? oe_cnt_q + 10'h001 : 10'h000;
        end
    end
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESETN_I);
    // ==========================================
    // assertions
    apb_wait_a: assert property (PSEL_I && PENABLE_I && !$past(PENABLE_I) |=> PREADY_O)
        else $error("ready not on second access edge");
    ready_pulse_a: assert property (PREADY_O |=> !PREADY_O) else $error("ready held");
    err_cause_a: assert property (PSLVERR_O |-> PREADY_O && PADDR_I != 8'h00
        && PADDR_I != 8'h04 && PADDR_I != 8'h08 && PADDR_I != 8'h0C)
        else $error("error on mapped address");
    send_delay_a: assert property (wr_data && mode_q == 2'b00
        |=> (!PORT3_LINE0_OE_O)[*8]) else $error("send too early");
    send_len_a: assert property ($fell(PORT3_LINE0_OE_O)
        |-> oe_cnt_q >= 8 * MC_CLKS && oe_cnt_q <= 10 * MC_CLKS) else $error("send length");
    send_end_a: assert property (wr_data && mode_q == 2'b00
        |-> ##[1:D_M0] $fell(PORT3_LINE0_OE_O)) else $error("send never ended");
    uart_no_oe_a: assert property (mode_q != 2'b00 |-> !PORT3_LINE0_OE_O)
        else $error("data pin driven in uart mode");
    uart_start_a: assert property (wr_data && mode_q == 2'b01
        |-> ##[1:D_U1] !PORT3_LINE1_O) else $error("no start bit");
    start_len_a: assert property (mode_q == 2'b01 && $fell(PORT3_LINE1_O)
        |-> (!PORT3_LINE1_O)[*8]) else $error("start bit short");
endmodule // sp_checker
`default_nettype wire

/* File: testbench/sp_partner.sv */
`timescale 1ns/10ps
`default_nettype none
module sp_partner #(
    parameter int BIT_CLKS = 128  // clocks per uart bit
) (
    input  wire logic       clk_i,
    input  wire logic       uart_i,    // high for uart framing
    input  wire logic       clear_i,   // restart shift counts
    input  wire logic       go_i,      // send one uart frame
    input  wire logic [7:0] rx_byte_i, // byte that we send
    input  wire logic       line0_i,   // resolved data wire
    input  wire logic       line1_i,   // shift clock or uart line
    input  wire logic       oe_i,
    output logic            line_o,
    output logic      [7:0] cap_o,
    output logic      [3:0] ncap_o,
    output logic      [7:0] ubyte_o,
    output logic            ustop_o
);
    logic [3:0] idx = 4'h0;
    logic       utx = 1'b1;  // idle high, like the pull-up
    // bit k shows after the k-th rising clock, sampled before the next one
    assign line_o = uart_i ? utx : ((idx > 4'h0 && idx < 4'h9)
                    ? rx_byte_i[3'(idx - 4'h1)] : 1'b1);
    always @(posedge line1_i or posedge clear_i) begin
        if (clear_i) begin
            idx <= 4'h0;
            ncap_o <= 4'h0;
        end else if (!uart_i && oe_i) begin
            cap_o <= {line0_i, cap_o[7:1]};
            ncap_o <= ncap_o + 4'h1;
        end else if (!uart_i) begin
            idx <= idx + 4'h1;  // next bit after the port sampled
        end
    end
    always @(negedge line1_i) begin
        if (uart_i) begin
            repeat (BIT_CLKS / 2) @(posedge clk_i);
            for (int i = 0; i < 9; i++) begin
                repeat (BIT_CLKS) @(posedge clk_i);
                if (i < 8) ubyte_o[i] = line1_i;
                else ustop_o = line1_i;
            end
        end
    end
    always @(posedge go_i) begin
        utx = 1'b0;
        repeat (BIT_CLKS) @(posedge clk_i);
        for (int i = 0; i < 9; i++) begin
            utx = (i < 8) ? rx_byte_i[i] : 1'b1;
            repeat (BIT_CLKS) @(posedge clk_i);
        end
    end
endmodule // sp_partner
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import sp_pkg::*;
    localparam int BIT_CLKS = 128;  // 16 ticks, one per 8-clock overflow
    logic        clk, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic        ovf = 1'b0, go = 1'b0, uart = 1'b0, clr = 1'b0;
    logic        pready, perr, l0o, oe, l1o, pline, ustop, err;
    logic [7:0]  paddr = 8'h00, rxb = 8'h00, cap, ubyte, b;
    logic [3:0]  ncap;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    int          num_errors = 0, n_checks = 0, cyc = 0;
    wire logic   line0 = oe ? l0o : pline;  // port wins while enabled
    sp_serial_port #(.MC_CLKS(SP_MC_CLKS)) dut (.CLK_SYS_I(clk), .RESETN_I(rst_n),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr),
        .TIMER_OVF_I(ovf), .PORT3_LINE0_I(line0), .PORT3_LINE0_O(l0o),
        .PORT3_LINE0_OE_O(oe), .PORT3_LINE1_O(l1o));
    sp_partner #(.BIT_CLKS(BIT_CLKS)) far (.clk_i(clk), .uart_i(uart), .clear_i(clr),
        .go_i(go), .rx_byte_i(rxb), .line0_i(line0), .line1_i(l1o), .oe_i(oe),
        .line_o(pline), .cap_o(cap), .ncap_o(ncap), .ubyte_o(ubyte), .ustop_o(ustop));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // overflow pulse every 160 ns, and the hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        ovf <= (cyc % 8 == 7);
        if (cyc == 40000) begin
            num_errors++;
            print_verdict();
        end
    end
    // ==========================================
    // tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer, held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50) num_errors++;
        rd = prdata;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic poll(input int bit_pos);
        int n;
        n = 0;
        do begin
            apb(1'b0, SP_CTRL_OFS, 32'h0);
            n++;
        end while (rd[bit_pos] !== 1'b1 && n < 1000);
    endtask
    task automatic pulse_clr();
        clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========================================
    // main sequence
    initial begin
        void'($urandom(32'h7b9e));
        repeat (5) @(posedge clk);
        chk("idle pins", 3'b100, {l1o, oe, pready});
        @(posedge clk) rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, SP_CTRL_OFS, 32'h0);
        chk("ctrl reset", {24'h0, SP_CTRL_RST}, rd);
        b = 8'($urandom);
        apb(1'b1, SP_BAUD_OFS, {24'h0, b});
        apb(1'b0, SP_BAUD_OFS, 32'h0);
        chk("baud", {24'h0, b}, rd & 32'h0000_ffff);
        apb(1'b1, SP_BAUD_OFS, {16'h0, SP_BAUD_RST});
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, SP_CTRL_OFS, 32'(m << 6));
            apb(1'b0, SP_CTRL_OFS, 32'h0);
            chk("mode", 32'(m), 32'(rd[7:6]));
        end
        // mode 0 send: edge bytes first
        for (int k = 0; k < 3; k++) begin
            b = (k == 0) ? 8'h80 : (k == 1) ? 8'h01 : 8'($urandom);
            apb(1'b1, SP_CTRL_OFS, 32'h0);
            pulse_clr();
            apb(1'b1, SP_DATA_OFS, {24'h0, b});
            poll(SP_TX_DONE_BIT);
            chk("send done", 1, rd[SP_TX_DONE_BIT]);
            chk("send byte", {b, 4'h8}, {cap, ncap});
        end
        // mode 0 receive, then flag keeps new reception out
        rxb <= 8'($urandom);
        apb(1'b1, SP_CTRL_OFS, 32'h0);
        pulse_clr();
        apb(1'b1, SP_CTRL_OFS, 32'h1 << SP_REN_BIT);
        poll(SP_RX_DONE_BIT);
        chk("recv done", 1, rd[SP_RX_DONE_BIT]);
        apb(1'b0, SP_DATA_OFS, 32'h0);
        chk("recv byte", {24'h0, rxb}, rd);
        repeat (30 * SP_MC_CLKS) @(posedge clk);
        apb(1'b0, SP_STATUS_OFS, 32'h0);
        chk("no restart", 0, rd[2]);
        apb(1'b0, SP_CTRL_OFS, 32'h0);
        chk("flag kept", 1, rd[SP_RX_DONE_BIT]);
        // uart send: 00, ff and random bytes
        uart <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            b = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
            apb(1'b1, SP_CTRL_OFS, 32'h40);
            apb(1'b1, SP_DATA_OFS, {24'h0, b});
            poll(SP_TX_DONE_BIT);
            chk("uart byte", {b, 1'b1}, {ubyte, ustop});
            chk("uart idle", 1, l1o);
        end
        // uart receive: refused without enable, then taken
        rxb <= 8'($urandom);
        apb(1'b1, SP_CTRL_OFS, 32'h40);
        go <= 1'b1;
        repeat (11 * BIT_CLKS) @(posedge clk) go <= 1'b0;
        apb(1'b0, SP_CTRL_OFS, 32'h0);
        chk("rx off", 0, rd[SP_RX_DONE_BIT]);
        apb(1'b1, SP_CTRL_OFS, 32'h50);
        go <= 1'b1;
        poll(SP_RX_DONE_BIT);
        go <= 1'b0;
        chk("stop stored", 1, rd[SP_NINTH_RX_BIT]);
        apb(1'b0, SP_DATA_OFS, 32'h0);
        chk("uart rx", {24'h0, rxb}, rd);
        print_verdict();
    end
endmodule // tb_top
bind sp_serial_port sp_checker #(.MC_CLKS(MC_CLKS)) chk_i (.CLK_SYS_I(CLK_SYS_I),
    .RESETN_I(RESETN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
    .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .PORT3_LINE0_OE_O(PORT3_LINE0_OE_O), .PORT3_LINE1_O(PORT3_LINE1_O));
`default_nettype wire
